// ---- shared/bls_pkg.sv ----
// ****************************************************************
// boot load status constants
// ****************************************************************
package bls_pkg;

    // register byte addresses
    localparam logic [31:0] ADDR_PROGRESS  = 32'h0001_D3B8;
    localparam logic [31:0] ADDR_CONFIG    = 32'h0001_D3BC;

    // field widths
    localparam int          PAIRS_W        = 16;
    localparam int          BYTE_ADDR_W    = 16;
    localparam int          DEV_ADDR_W     = 7;
    localparam int          CHAIN_ZERO_W   = 3;

    // progress register layout
    localparam int          PAIRS_LSB      = 16;
    localparam int          BYTE_ADDR_LSB  = 0;

    // configuration view layout
    localparam int          BOOTING_BIT    = 31;
    localparam int          INHIBIT_BIT    = 30;
    localparam int          PTR_WIDTH_BIT  = 29;
    localparam int          PAGE_INC_BIT   = 28;
    localparam int          DEV_ADDR_LSB   = 0;

    // reset values
    localparam logic [15:0] PAIRS_RST      = 16'h0000;
    localparam logic [15:0] BYTE_ADDR_RST  = 16'h0000;
    localparam logic [6:0]  DEV_ADDR_RST   = 7'h00;
    localparam logic        BOOTING_RST    = 1'b0;
    localparam logic        PAGE_INC_RST   = 1'b0;
    localparam logic        PTR_WIDTH_RST  = 1'b0;
    localparam logic        INHIBIT_RST    = 1'b0;
    localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

    // loader progress phases
    typedef enum logic [1:0] {
        BLS_IDLE,
        BLS_COUNT_HI,
        BLS_COUNT_LO,
        BLS_PAIRS
    } bls_state_e;

endpackage

// ---- src/bls_counter.sv ----
`timescale 1ns/1ps
// ****************************************************************
// loadable up/down counter
// ****************************************************************
module bls_counter #(
    parameter int             W   = 16,
    parameter logic [W-1:0]   RST = '0
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    // controls, load beats step
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_val_i,
    input  wire logic         inc_i,
    input  wire logic         dec_i,
    // value
    output logic      [W-1:0] count_o
);

    localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

    logic [W-1:0] count;
    logic [W-1:0] next_count;

    // load first, then increment, then decrement
    always_comb begin
        next_count = count;
        if (load_i) begin
            next_count = load_val_i;
        end else if (inc_i) begin
            next_count = count + ONE;
        end else if (dec_i) begin
            next_count = count - ONE;
        end
    end

    // register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count <= RST;
        end else begin
            count <= next_count;
        end
    end

    assign count_o = count;

endmodule

// ---- src/bls_boot_status.sv ----
// Local design decision: the APB register port.
`timescale 1ns/1ps
// ****************************************************************
// boot load progress and configuration status view
// ****************************************************************
module bls_boot_status (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // boot engine events
    input  wire logic        boot_start_i,
    input  wire logic        boot_end_i,
    input  wire logic        chain_i,
    input  wire logic        byte_valid_i,
    input  wire logic [7:0]  byte_data_i,
    input  wire logic        pair_done_i,
    input  wire logic        dev_step_i,
    input  wire logic        load_inhibited_i,
    // boot control settings
    input  wire logic        control_pointer_width_i,
    input  wire logic        ctrl_page_inc_i,
    input  wire logic [6:0]  ctrl_dev_addr_i,
    input  wire logic [15:0] ctrl_chain_addr_i
);

    // ****************************************************************
    // state
    // ****************************************************************
    bls_pkg::bls_state_e state;
    bls_pkg::bls_state_e next_state;
    logic                booting;
    logic                next_booting;
    logic                rom_pointer_width;
    logic                next_rom_pointer_width;
    logic                device_select_advance;
    logic                next_device_select_advance;
    logic                load_inhibited;
    logic                next_load_inhibited;

    logic [15:0]         pairs_remaining;
    logic [15:0]         byte_addr;
    logic [6:0]          dev_addr;

    logic                start_take;
    logic                chain_take;
    logic                restart;
    logic                byte_take;
    logic                pairs_load;
    logic [15:0]         pairs_load_val;
    logic                pairs_dec;
    logic                dev_inc;

    // helpers for the counter load values and for checking
    logic [7:0]          pairs_hi;
    logic [12:0]         chain_hi;

    // ****************************************************************
    // event qualification
    // ****************************************************************
    // chain only means something while a sequence runs
    assign start_take = boot_start_i;
    assign chain_take = chain_i & booting;
    assign restart    = start_take | chain_take;
    // a byte in the restart cycle belongs to the old image, so drop it
    assign byte_take  = byte_valid_i & booting & ~restart;
    assign pairs_hi   = pairs_remaining[15:8];
    assign chain_hi   = ctrl_chain_addr_i[15:3];

    // phase, booting flag and captured settings
    always_comb begin
        next_state                 = state;
        next_booting               = booting;
        next_rom_pointer_width     = rom_pointer_width;
        next_device_select_advance = device_select_advance;
        next_load_inhibited        = load_inhibited_i;
        if (restart) begin
            next_state             = bls_pkg::BLS_COUNT_HI;
            next_booting           = 1'b1;
            next_rom_pointer_width = control_pointer_width_i;
            if (start_take) begin
                next_device_select_advance = ctrl_page_inc_i;
            end
        end else if (boot_end_i) begin
            next_state   = bls_pkg::BLS_IDLE;
            next_booting = 1'b0;
        end else if (byte_take) begin
            case (state)
                bls_pkg::BLS_COUNT_HI: begin
                    next_state = bls_pkg::BLS_COUNT_LO;
                end
                bls_pkg::BLS_COUNT_LO: begin
                    next_state = bls_pkg::BLS_PAIRS;
                end
                default: begin
                    next_state = state;
                end
            endcase
        end
    end

    // register the phase group
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state                 <= bls_pkg::BLS_IDLE;
            booting               <= bls_pkg::BOOTING_RST;
            rom_pointer_width     <= bls_pkg::PTR_WIDTH_RST;
            device_select_advance <= bls_pkg::PAGE_INC_RST;
            load_inhibited        <= bls_pkg::INHIBIT_RST;
        end else begin
            state                 <= next_state;
            booting               <= next_booting;
            rom_pointer_width     <= next_rom_pointer_width;
            device_select_advance <= next_device_select_advance;
            load_inhibited        <= next_load_inhibited;
        end
    end

    // ****************************************************************
    // counters
    // ****************************************************************
    // count is big endian: first byte is the high half
    assign pairs_load     = byte_take & ((state == bls_pkg::BLS_COUNT_HI) |
                                         (state == bls_pkg::BLS_COUNT_LO));
    assign pairs_load_val = (state == bls_pkg::BLS_COUNT_HI) ?
                            {byte_data_i, 8'h00} : {pairs_hi, byte_data_i};
    // never wraps below zero if the engine over-reports
    assign pairs_dec      = pair_done_i & booting & ~restart & ~boot_end_i &
                            (state == bls_pkg::BLS_PAIRS) &
                            (pairs_remaining != 16'h0000);
    assign dev_inc        = dev_step_i & device_select_advance & booting &
                            ~restart;

    bls_counter #(
        .W          (bls_pkg::PAIRS_W),
        .RST        (bls_pkg::PAIRS_RST)
    ) u_pairs (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .load_i     (pairs_load),
        .load_val_i (pairs_load_val),
        .inc_i      (1'b0),
        .dec_i      (pairs_dec),
        .count_o    (pairs_remaining)
    );

    bls_counter #(
        .W          (bls_pkg::BYTE_ADDR_W),
        .RST        (bls_pkg::BYTE_ADDR_RST)
    ) u_byte_addr (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .load_i     (chain_take),
        .load_val_i ({chain_hi, {bls_pkg::CHAIN_ZERO_W{1'b0}}}),
        .inc_i      (byte_take),
        .dec_i      (1'b0),
        .count_o    (byte_addr)
    );

    bls_counter #(
        .W          (bls_pkg::DEV_ADDR_W),
        .RST        (bls_pkg::DEV_ADDR_RST)
    ) u_dev_addr (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .load_i     (restart),
        .load_val_i (ctrl_dev_addr_i),
        .inc_i      (dev_inc),
        .dec_i      (1'b0),
        .count_o    (dev_addr)
    );

    // ****************************************************************
    // apb slave
    // ****************************************************************
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [31:0] progress_word;
    logic [31:0] config_word;
    logic        access;

    // one wait state keeps every answer straight from a flop
    assign access = psel_i & penable_i & ~pready_o;

    // status words, reserved bits tied low
    always_comb begin
        progress_word = 32'h0000_0000;
        config_word   = 32'h0000_0000;
        progress_word[bls_pkg::PAIRS_LSB +: bls_pkg::PAIRS_W] = pairs_remaining;
        progress_word[bls_pkg::BYTE_ADDR_LSB +: bls_pkg::BYTE_ADDR_W] = byte_addr;
        config_word[bls_pkg::BOOTING_BIT]   = booting;
        config_word[bls_pkg::INHIBIT_BIT]   = load_inhibited;
        config_word[bls_pkg::PTR_WIDTH_BIT] = rom_pointer_width;
        config_word[bls_pkg::PAGE_INC_BIT]  = device_select_advance;
        config_word[bls_pkg::DEV_ADDR_LSB +: bls_pkg::DEV_ADDR_W] = dev_addr;
    end

    // answer: writes are accepted and dropped, unmapped gives an error
    always_comb begin
        next_prdata  = prdata_o;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (access) begin
            next_pready = 1'b1;
            next_prdata = bls_pkg::RDATA_RST;
            if (paddr_i == bls_pkg::ADDR_PROGRESS) begin
                if (!pwrite_i) begin
                    next_prdata = progress_word;
                end
            end else if (paddr_i == bls_pkg::ADDR_CONFIG) begin
                if (!pwrite_i) begin
                    next_prdata = config_word;
                end
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    // register the bus answer
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prdata_o  <= bls_pkg::RDATA_RST;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            prdata_o  <= next_prdata;
            pready_o  <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    AST_COUNT_LOAD: assert property (
        (byte_take && state == bls_pkg::BLS_COUNT_LO) |=>
        (pairs_remaining[7:0] == $past(byte_data_i)) &&
        (pairs_remaining[15:8] == $past(pairs_hi)))
        else $error("pair count not built from first two bytes");

    AST_CHAIN_RELOAD: assert property (
        chain_take |=>
        (state == bls_pkg::BLS_COUNT_HI) && booting)
        else $error("chain did not restart the count phase");

    AST_COUNT_DOWN: assert property (
        pairs_dec |=> pairs_remaining == $past(pairs_remaining) - 16'h0001)
        else $error("pair count did not step down");

    AST_BYTE_ADVANCE: assert property (
        byte_take |=> byte_addr == $past(byte_addr) + 16'h0001)
        else $error("byte address did not advance");

    AST_CHAIN_ADDR: assert property (
        chain_take |=> (byte_addr[2:0] == 3'h0) &&
        (byte_addr[15:3] == $past(chain_hi)))
        else $error("chain address not loaded with low bits clear");

    AST_BOOTING: assert property (
        (boot_end_i && !restart) |=> !booting ##1 (!booting || $past(restart)))
        else $error("booting flag wrong after end");

    AST_PTR_WIDTH: assert property (
        restart |=> rom_pointer_width == $past(control_pointer_width_i))
        else $error("pointer width not captured");

    AST_PAGE_INC: assert property (
        !start_take |=> $stable(device_select_advance))
        else $error("page increment bit changed without start");

    AST_DEV_HOLD: assert property (
        (!device_select_advance && !restart) |=> $stable(dev_addr))
        else $error("device address moved without page increment");

    AST_RESERVED: assert property (
        (access && !pwrite_i && paddr_i == bls_pkg::ADDR_CONFIG) |=>
        pready_o && (prdata_o[27:7] == 21'h000000))
        else $error("reserved bits not zero");

endmodule

// ---- dv/bls_rom_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// serial rom byte source for the boot engine side
// ****************************************************************
module bls_rom_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // fetch request and pacing
    input  wire logic       fetch_i,
    input  wire logic       slow_i,
    // fetched byte
    output logic            byte_valid_o,
    output logic      [7:0] byte_data_o
);
    logic [7:0] mem [64];
    logic [5:0] ptr;
    logic [2:0] wait_cnt;
    logic       busy;

    // one byte per request; data toggles when not valid so stale bytes never match
    always_ff @(posedge clk_i) begin
        byte_valid_o <= 1'b0;
        if (srst_i) begin
            ptr         <= 6'h00;
            busy        <= 1'b0;
            wait_cnt    <= 3'h0;
            byte_data_o <= 8'h5A;
        end else if (busy && wait_cnt == 3'h0) begin
            byte_valid_o <= 1'b1;
            byte_data_o  <= mem[ptr];
            ptr          <= ptr + 6'h01;
            busy         <= 1'b0;
        end else begin
            byte_data_o <= ~byte_data_o;
            if (busy) begin
                wait_cnt <= wait_cnt - 3'h1;
            end else if (fetch_i) begin
                busy     <= 1'b1;
                wait_cnt <= slow_i ? 3'h3 : 3'h0; // slow rom stretches each byte
            end
        end
    end
endmodule

// ---- dv/bls_boot_status_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
// ****************************************************************
// boot load status bench
// ****************************************************************
module bls_boot_status_tb_top;
    logic clk_i = 0, srst_i = 1, psel = 0, penable = 0, pwrite = 0, fetch = 0, slow = 0;
    logic [31:0] paddr = '0, pwdata = '0, prdata_o, seed = 32'h0000_0025;
    logic        pready_o, pslverr_o, byte_valid_o, inh = 0, pw = 0, pi = 0;
    logic [7:0]  byte_data_o, img [64];
    logic [4:0]  ev = '0;
    logic [6:0]  dev = '0, exp_dev = '0;
    logic [15:0] ca = '0, exp_cnt = '0, exp_addr = '0;
    logic        exp_boot = 0, exp_pw = 0, exp_pi = 0, exp_inh = 0;
    int          num_errors = 0, n_checks = 0, bp = 0;

    always #10 clk_i = ~clk_i;

    bls_boot_status i_bls_boot_status (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .boot_start_i(ev[4]), .boot_end_i(ev[3]), .chain_i(ev[2]),
        .byte_valid_i(byte_valid_o), .byte_data_i(byte_data_o), .pair_done_i(ev[1]),
        .dev_step_i(ev[0]), .load_inhibited_i(inh), .control_pointer_width_i(pw),
        .ctrl_page_inc_i(pi), .ctrl_dev_addr_i(dev), .ctrl_chain_addr_i(ca));

    bls_rom_model i_bls_rom_model (.clk_i(clk_i), .srst_i(srst_i), .fetch_i(fetch),
        .slow_i(slow), .byte_valid_o(byte_valid_o), .byte_data_o(byte_data_o));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected register images from the tracked loader state
    function logic [31:0] prog_word();
        return {exp_cnt, exp_addr};
    endfunction

    function logic [31:0] cfg_word();
        return {exp_boot, exp_inh, exp_pw, exp_pi, 21'h000000, exp_dev};
    endfunction

    task summarize();
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task apb(input logic wr, input logic [31:0] a, output logic [31:0] rd, output logic err);
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= rnd();
        @(posedge clk_i);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a hung wait
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task chk_regs();
        logic [31:0] d;
        logic        e;
        apb(1'b0, bls_pkg::ADDR_PROGRESS, d, e);
        `CHK({e, d}, {1'b0, prog_word()})
        apb(1'b0, bls_pkg::ADDR_CONFIG, d, e);
        `CHK({e, d}, {1'b0, cfg_word()})
    endtask

    task fire(input logic [4:0] e);
        @(posedge clk_i);
        ev <= e;
        @(posedge clk_i);
        ev <= 5'h00;
    endtask

    // fetch one byte; mirror its effect on count and byte address
    task get_byte(input int which);
        @(posedge clk_i);
        fetch <= 1'b1;
        @(posedge clk_i);
        fetch <= 1'b0;
        while (byte_valid_o !== 1'b1) begin
            @(posedge clk_i);
        end
        if (which == 0) exp_cnt = {img[bp], 8'h00};
        if (which == 1) exp_cnt = {exp_cnt[15:8], img[bp]};
        bp++;
        exp_addr = exp_addr + 16'h0001;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [31:0] d;
        logic        e;
        for (int i = 0; i < 64; i++) img[i] = rnd();
        img[1] = 8'h02; // small first count so the floor at zero is reached
        img[0] = 8'h00;
        for (int i = 0; i < 64; i++) i_bls_rom_model.mem[i] = img[i];
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        chk_regs();
        for (int r = 0; r < 4; r++) begin
            d = rnd();
            {inh, pw, dev} <= {d[9], d[8], d[6:0]};
            pi   <= r[0];
            slow <= r[1];
            @(posedge clk_i);
            {exp_inh, exp_pw, exp_pi, exp_dev, exp_boot} = {inh, pw, pi, dev, 1'b1};
            fire(5'h10);
            get_byte(0);
            get_byte(1);
            chk_regs();
            repeat (3) fire(5'h02);
            exp_cnt = (exp_cnt > 16'h0003) ? exp_cnt - 16'h0003 : 16'h0000;
            fire(5'h01);
            if (exp_pi) exp_dev = exp_dev + 7'h01;
            chk_regs();
            d = rnd();
            {pw, ca} <= {d[31], d[15:0]};
            pi <= ~pi; // page increment is not recaptured on chain
            @(posedge clk_i);
            // chain reloads the device address from the control setting
            {exp_pw, exp_addr, exp_dev} = {pw, ca & 16'hFFF8, dev};
            fire(5'h04);
            get_byte(0);
            get_byte(1);
            chk_regs();
            apb(1'b1, bls_pkg::ADDR_PROGRESS, d, e);
            `CHK(e, 1'b0)
            apb(1'b1, bls_pkg::ADDR_CONFIG, d, e);
            `CHK(e, 1'b0)
            apb(1'b0, 32'h0001_D3C0, d, e);
            `CHK({e, d}, {1'b1, 32'h0000_0000})
            chk_regs();
            fire(5'h08);
            exp_boot = 1'b0;
            fire(5'h04);
            chk_regs();
        end
        // mid-run reset must clear every field the rounds have built up except the inhibit bit, which follows its input again
        srst_i <= 1'b1;
        @(posedge clk_i);
        srst_i <= 1'b0;
        {exp_cnt, exp_addr, exp_dev, exp_pw, exp_pi, exp_boot} = '0;
        bp = 0;
        chk_regs();
        {exp_pw, exp_pi, exp_dev, exp_boot} = {pw, pi, dev, 1'b1};
        fire(5'h10);
        get_byte(0);
        get_byte(1);
        chk_regs();
        summarize();
    end

    // watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        summarize();
    end
endmodule
